// ==== core/flash_bus_regs.vh ====
// Constants for the parallel flash bus controller
`ifndef FLASH_BUS_REGS_VH
`define FLASH_BUS_REGS_VH
`define ADDR_W          17
`define DATA_W          8
`define SECTOR_HI       16
`define SECTOR_LO       15
`define ID_HV_BIT       9
`define ID_A6_BIT       6
`define ID_SEL_MFR      2'h0
`define ID_SEL_DEV      2'h1
`define ID_SEL_PROT     2'h2
`define ID_SEL_CONT     2'h3
`define PROT_YES        8'h01
`define PROT_NO         8'h00
`define ACCESS_NS       70
`define SETUP_NS        10
`define CLK_NS          4
`define OP_READ         2'h0
`define OP_WRITE        2'h1
`define OP_IDREAD       2'h2
`define OP_PROTREAD     2'h3
`endif

// ==== core/sync2.v ====
// Two-flop synchroniser for bus inputs
`timescale 1ns/10ps
module sync2 #(
   parameter W = 8
) (
   input  wire         clk_sys,
   input  wire         rstn,
   input  wire [W-1:0] d,
   output wire [W-1:0] q
);
   reg [W-1:0] meta_reg;
   reg [W-1:0] q_reg;
   always @(posedge clk_sys) begin
      if (!rstn) begin
         meta_reg <= {W{1'b0}};
         q_reg    <= {W{1'b0}};
      end else begin
         meta_reg <= d;
         q_reg    <= meta_reg;
      end
   end
   assign q = q_reg;
endmodule // sync2

// ==== core/flash_bus_host.v ====
// Host controller driving an asynchronous parallel flash bus
// Operation
// R1: Read: chip select and output enable low, write high, address valid, sample data.
// R2: Write: chip select and write low, output enable high, address and data valid.
// R3: Output disable: device floats data when output enable high.
// R4: Chip select high puts device in standby, data floated.
// R5: Device starts in read-array mode after power-up or reset.
// R6: Device stays in read-array mode until a write changes command latches.
// R7: Command latches map to no array address.
// R8: Deselect during program or erase lets the operation finish internally.
// R9: Sector is address bits 16 and 15, four 32K sectors ascending.
// R10: Erase may cover one sector, several, or whole array.
// R11: During program or erase, reads return status bits.
// R12: After autoselect command, reads return identification codes.
// R13: High-voltage ID: bit 9 raised, bit 6 low, bits 1:0 select code.
// R14: Protection verify: sector on top bits, 01h protected, 00h not.
// R15: ID codes are 8 bits; other address bits don't care.
// R16: Command autoselect works without the high voltage.
// R17: Autoselect persists until the reset command returns read-array.
// R18: Device takes address on later falling edge, data on earlier rising.
`timescale 1ns/10ps
`include "flash_bus_regs.vh"
module flash_bus_host #(
   parameter ACCESS_NS = `ACCESS_NS,
   parameter SETUP_NS  = `SETUP_NS
) (
   input  wire                 clk_sys,
   input  wire                 rstn,
   input  wire                 req_valid,
   output wire                 req_ready,
   input  wire [1:0]           req_op,
   input  wire [`ADDR_W-1:0]   req_addr,
   input  wire [`DATA_W-1:0]   req_wdata,
   output reg                  rsp_valid,
   output reg  [`DATA_W-1:0]   rsp_rdata,
   output reg                  rsp_protected,
   output reg  [`ADDR_W-1:0]   flash_addr,
   output reg                  flash_ce_n,
   output reg                  flash_oe_n,
   output reg                  flash_we_n,
   output reg                  flash_id_hv,
   output reg  [`DATA_W-1:0]   flash_dq_o,
   output reg                  flash_dq_oe_n,
   input  wire [`DATA_W-1:0]   flash_dq_i
);
   // Least times round up to whole cycles
   localparam integer ACC_NUM = (ACCESS_NS + `CLK_NS - 1) / `CLK_NS;
   localparam integer SU_NUM  = (SETUP_NS + `CLK_NS - 1) / `CLK_NS;
   localparam [7:0]   ACC_CYC = ACC_NUM[7:0];
   localparam [7:0]   SU_CYC  = SU_NUM[7:0];
   // Sampled data must clear two flops after the access time
   localparam [7:0] RD_WAIT = ACC_CYC + 8'h02;

   localparam [2:0] ST_IDLE   = 3'h0;
   localparam [2:0] ST_SETUP  = 3'h1;
   localparam [2:0] ST_STROBE = 3'h2;
   localparam [2:0] ST_HOLD   = 3'h3;
   localparam [2:0] ST_DONE   = 3'h4;

   reg [2:0]  state_reg;
   reg [2:0]  state_next;
   reg [7:0]  cnt_reg;
   reg [1:0]  op_reg;
   wire [`DATA_W-1:0] dq_sync;

   function is_read;
      input [1:0] op;
      begin
         is_read = (op != `OP_WRITE);
      end
   endfunction

   function is_id;
      input [1:0] op;
      begin
         is_id = (op == `OP_IDREAD) || (op == `OP_PROTREAD);
      end
   endfunction

   // Strobe low time in cycles less one, by direction
   function [7:0] strobe_len;
      input rd;
      begin
         strobe_len = rd ? RD_WAIT : ACC_CYC;
      end
   endfunction

   // Only selector, sector and A6 matter while the ID voltage is up
   function [`ADDR_W-1:0] id_addr;
      input [1:0]         op;
      input [`ADDR_W-1:0] a;
      begin
         id_addr = {`ADDR_W{1'b0}};                                    // R15
         if (op == `OP_PROTREAD) begin
            id_addr[1:0]                   = `ID_SEL_PROT;
            id_addr[`SECTOR_HI:`SECTOR_LO] = a[`SECTOR_HI:`SECTOR_LO]; // R14
         end else begin
            id_addr[1:0] = a[1:0];
         end
         id_addr[`ID_A6_BIT] = 1'b0;                                   // R13
      end
   endfunction

   sync2 #(.W(`DATA_W)) u_dq_sync (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .d       (flash_dq_i),
      .q       (dq_sync)
   );

   assign req_ready = (state_reg == ST_IDLE);

   // Phase ends, each true for a single cycle; rd_op and id_op decode the operation
   wire take_w     = req_valid && req_ready;
   wire setup_end  = (state_reg == ST_SETUP) && (cnt_reg == 8'h00);
   wire strobe_end = (state_reg == ST_STROBE) && (cnt_reg == 8'h00);
   wire hold_end   = (state_reg == ST_HOLD) && (cnt_reg == 8'h00);
   wire rd_op      = is_read(op_reg);
   wire id_op      = is_id(req_op);

   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:   if (take_w) state_next = ST_SETUP;
         ST_SETUP:  if (setup_end) state_next = ST_STROBE;
         ST_STROBE: if (strobe_end) state_next = ST_HOLD;
         ST_HOLD:   if (hold_end) state_next = ST_DONE;
         ST_DONE:   state_next = ST_IDLE;
         default:   state_next = ST_IDLE;
      endcase
   end

   // Sequencer: the phase counter reloads on entry to setup, strobe and hold
   always @(posedge clk_sys) begin
      if (!rstn) begin
         state_reg <= ST_IDLE;
         cnt_reg   <= 8'h00;
         op_reg    <= `OP_READ;
      end else begin
         state_reg <= state_next;
         if (take_w) begin
            op_reg  <= req_op;
            cnt_reg <= SU_CYC - 8'h01;
         end else if (setup_end) begin
            cnt_reg <= strobe_len(rd_op);
         end else if (strobe_end) begin
            cnt_reg <= SU_CYC - 8'h01;
         end else if (cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
         end
      end
   end

   // Address and ID level stay put from take until deselect
   always @(posedge clk_sys) begin
      if (!rstn) begin
         flash_addr  <= {`ADDR_W{1'b0}};
         flash_id_hv <= 1'b0;
      end else if (take_w) begin
         flash_id_hv <= id_op;                                         // R13
         flash_addr  <= id_op ? id_addr(req_op, req_addr) : req_addr;  // R13 R14 R15
      end else if (hold_end) begin
         flash_id_hv <= 1'b0;
      end
   end

   // Address already stable before both falling edges
   always @(posedge clk_sys) begin
      if (!rstn) begin
         flash_ce_n <= 1'b1;                                           // R4
         flash_oe_n <= 1'b1;
         flash_we_n <= 1'b1;
      end else if (setup_end) begin
         flash_ce_n <= 1'b0;
         flash_oe_n <= !rd_op;                                         // R1
         flash_we_n <= rd_op;                                          // R2 R18
      end else if (strobe_end) begin
         // Rising strobe latches data; data held through hold state
         flash_oe_n <= 1'b1;
         flash_we_n <= 1'b1;                                           // R18
      end else if (hold_end) begin
         // Deselect is safe even mid erase; device finishes alone
         flash_ce_n <= 1'b1;                                           // R4 R8
      end else if (state_reg > ST_DONE) begin
         flash_ce_n <= 1'b1;
         flash_oe_n <= 1'b1;
         flash_we_n <= 1'b1;
      end
   end

   // Host drives data only from take until deselect
   always @(posedge clk_sys) begin
      if (!rstn) begin
         flash_dq_o    <= 8'h00;
         flash_dq_oe_n <= 1'b1;
      end else if (take_w && req_op == `OP_WRITE) begin
         // Commands, the reset command too, are plain writes
         flash_dq_o    <= req_wdata;                                   // R2 R17
         flash_dq_oe_n <= 1'b0;
      end else if (hold_end) begin
         flash_dq_oe_n <= 1'b1;                                        // R3
      end
   end

   // One pulse per operation, writes included
   always @(posedge clk_sys) begin
      if (!rstn) begin
         rsp_valid <= 1'b0;
      end else begin
         rsp_valid <= (state_reg == ST_DONE);
      end
   end

   // Read data holds until the next read; sampled bus is settled by now
   always @(posedge clk_sys) begin
      if (!rstn) begin
         rsp_rdata     <= 8'h00;
         rsp_protected <= 1'b0;
      end else if (strobe_end && rd_op) begin
         rsp_rdata     <= dq_sync;                                     // R1 R11 R12
         rsp_protected <= (op_reg == `OP_PROTREAD) &&
                          (dq_sync == `PROT_YES);                      // R14
      end
   end
endmodule // flash_bus_host

// ==== dv/flash_bus_host_chk.sv ====
// Bus protocol checker for the flash bus host
`timescale 1ns/10ps
module flash_bus_host_chk (
   input logic        clk_sys, rstn, req_valid, req_ready, rsp_valid,
   input logic [16:0] flash_addr,
   input logic [7:0]  flash_dq_o,
   input logic        flash_ce_n, flash_oe_n, flash_we_n, flash_id_hv, flash_dq_oe_n
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   property p_rd; !flash_oe_n |-> !flash_ce_n && flash_we_n && flash_dq_oe_n; endproperty
   a_rd: assert property (p_rd) else $error("read strobes wrong");
   property p_wr; !flash_we_n |-> !flash_ce_n && flash_oe_n && !flash_dq_oe_n; endproperty
   a_wr: assert property (p_wr) else $error("write strobes wrong");
   property p_rdlen; $fell(flash_oe_n) |-> !flash_oe_n [*8]; endproperty
   a_rdlen: assert property (p_rdlen) else $error("read strobe too short");
   property p_take; req_valid && req_ready |=> !req_ready [*8]; endproperty
   a_take: assert property (p_take) else $error("ready during op");
   property p_pulse; rsp_valid |=> !rsp_valid && req_ready; endproperty
   a_pulse: assert property (p_pulse) else $error("response not one cycle");
   property p_end; rsp_valid |-> flash_ce_n && flash_dq_oe_n; endproperty
   a_end: assert property (p_end) else $error("bus not released at end");
   property p_hv; flash_id_hv |-> !flash_addr[6] && flash_addr[14:7] == 8'h00
      && flash_addr[5:2] == 4'h0; endproperty
   a_hv: assert property (p_hv) else $error("id address wrong");
   property p_addr; !flash_ce_n && !$past(flash_ce_n) |-> $stable(flash_addr); endproperty
   a_addr: assert property (p_addr) else $error("address moved");
   property p_dq; !flash_we_n && !$past(flash_we_n) |-> $stable(flash_dq_o); endproperty
   a_dq: assert property (p_dq) else $error("write data moved");
   c_rd: cover property ($fell(flash_oe_n));
   c_wr: cover property ($fell(flash_we_n));
   c_hv: cover property ($rose(flash_id_hv));
endmodule // flash_bus_host_chk
bind flash_bus_host flash_bus_host_chk chk_u (.clk_sys, .rstn, .req_valid, .req_ready,
   .rsp_valid, .flash_addr, .flash_dq_o, .flash_ce_n, .flash_oe_n, .flash_we_n,
   .flash_id_hv, .flash_dq_oe_n);

// ==== dv/flash_model.sv ====
// Behavioural flash device on the far side of the bus
`timescale 1ns/10ps
module flash_model #(
   // Identity values are arbitrary
   parameter [7:0] MFR = 8'h5a, DEV = 8'hc3, CONT = 8'h3c,
   parameter [3:0] PROT = 4'h5,
   // Command and status codes are arbitrary; BUSY is the erase time in ns
   parameter [7:0] CMD_ID = 8'h90, CMD_RST = 8'hf0, CMD_SEC = 8'h30, CMD_ALL = 8'h10,
   parameter [7:0] STAT = 8'h08, ERASED = 8'hff,
   parameter       BUSY = 2000,
   parameter       ACC  = 0
) (
   input wire [16:0] flash_addr,
   input wire        flash_ce_n, flash_oe_n, flash_we_n, flash_id_hv, flash_dq_oe_n,
   input wire [7:0]  flash_dq_o,
   output wire [7:0] flash_dq_i
);
   reg [7:0]  mem [0:131071];
   reg [7:0]  last;
   reg        asel;
   reg        busy;
   reg [16:0] a_lat;
   integer    i;
   wire       rd = !flash_ce_n && !flash_oe_n && flash_we_n;
   wire [1:0] sel = flash_addr[1:0];
   wire [7:0] code = sel == 2'h0 ? MFR : sel == 2'h1 ? DEV :
      sel == 2'h2 ? {7'h00, PROT[flash_addr[16:15]]} : CONT;
   wire [7:0] q = busy ? STAT :
      (asel || (flash_id_hv && !flash_addr[6])) ? code : mem[flash_addr];
   // Floating bus shows inverse of last value, never a stale match
   assign #(ACC) flash_dq_i = !flash_dq_oe_n ? flash_dq_o : rd ? q : ~last;
   always @* if (rd) last = q;
   initial begin
      asel = 1'b0;
      busy = 1'b0;
      last = 8'h00;
      for (i = 0; i < 131072; i = i + 1) mem[i] = i[7:0] ^ i[15:8];
   end
   always @(negedge (flash_ce_n | flash_we_n)) a_lat = flash_addr;
   // Writes reach the command latches only; erase runs on a timer, blind to deselect
   always @(posedge (flash_ce_n | flash_we_n)) begin
      if (flash_dq_o == CMD_ID) asel = 1'b1;
      else if (flash_dq_o == CMD_RST) asel = 1'b0;
      else if (flash_dq_o == CMD_SEC || flash_dq_o == CMD_ALL) begin
         busy = 1'b1;
         for (i = 0; i < 131072; i = i + 1)
            if (flash_dq_o == CMD_ALL || i[16:15] == a_lat[16:15]) mem[i] = ERASED;
         #(BUSY) busy = 1'b0;
      end
   end
endmodule // flash_model

// ==== dv/testbench.sv ====
// Self-checking bench for the flash bus host
`timescale 1ns/10ps
module testbench;
   reg         clk_sys, rstn, req_valid;
   reg  [1:0]  req_op;
   reg  [16:0] req_addr;
   reg  [7:0]  req_wdata;
   wire        req_ready, rsp_valid, rsp_protected, flash_ce_n, flash_oe_n, flash_we_n;
   wire        flash_id_hv, flash_dq_oe_n;
   wire [7:0]  rsp_rdata, flash_dq_o, flash_dq_i;
   wire [16:0] flash_addr;
   integer     bad_count = 0, n_tests = 0, i;
   localparam [7:0]  MFR = 8'h5a, DEV = 8'hc3, CONT = 8'h3c;
   localparam [7:0]  CMD_ID = 8'h90, CMD_RST = 8'hf0, CMD_SEC = 8'h30, CMD_ALL = 8'h10;
   localparam [7:0]  STAT = 8'h08, ERASED = 8'hff;
   localparam [3:0]  PROT = 4'h5;
   // OP_IDREAD high-voltage reads force sector zero, so the protect code is PROT bit 0
   localparam [31:0] CODES = {CONT, 8'h01, DEV, MFR};
   flash_bus_host dut_u (.clk_sys, .rstn, .req_valid, .req_ready, .req_op, .req_addr,
      .req_wdata, .rsp_valid, .rsp_rdata, .rsp_protected, .flash_addr, .flash_ce_n,
      .flash_oe_n, .flash_we_n, .flash_id_hv, .flash_dq_o, .flash_dq_oe_n, .flash_dq_i);
   flash_model #(.MFR(MFR), .DEV(DEV), .CONT(CONT), .PROT(PROT), .CMD_ID(CMD_ID),
      .CMD_RST(CMD_RST), .CMD_SEC(CMD_SEC), .CMD_ALL(CMD_ALL), .STAT(STAT),
      .ERASED(ERASED), .BUSY(2000), .ACC(60)) flash_u (
      .flash_addr, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_id_hv, .flash_dq_oe_n,
      .flash_dq_o, .flash_dq_i);
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   function [7:0] ex(input [16:0] a);
      ex = a[7:0] ^ a[15:8];
   endfunction
   task check(input [63:0] what, input [7:0] exp, input [7:0] seen);
      begin
         n_tests = n_tests + 1;
         if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("BAD %0s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   task op(input [1:0] o, input [16:0] a, input [7:0] d);
      integer k;
      begin
         @(posedge clk_sys);
         req_valid <= 1'b1; req_op <= o; req_addr <= a; req_wdata <= d;
         #1;
         while (req_ready !== 1'b1) begin @(posedge clk_sys); #1; end
         @(posedge clk_sys);
         req_valid <= 1'b0;
         k = 0;
         while (rsp_valid !== 1'b1 && k < 100) begin @(posedge clk_sys); #1; k = k + 1; end
         if (k == 100) check("timeout", 8'h00, 8'h01);
      end
   endtask
   task t_array;
      begin
         op(2'h0, 17'h1234a, 8'h00); check("array", ex(17'h1234a), rsp_rdata);
         op(2'h1, 17'h00100, 8'h55); op(2'h0, 17'h00100, 8'h00);
         check("array", ex(17'h00100), rsp_rdata);
      end
   endtask
   task t_cmd;
      begin
         op(2'h1, 17'h1234a, CMD_ID); op(2'h0, 17'h00001, 8'h00);
         check("dev", DEV, rsp_rdata);
         op(2'h0, 17'h1ffff, 8'h00); check("cont", CONT, rsp_rdata);
         op(2'h1, 17'h00000, CMD_RST); op(2'h0, 17'h1234a, 8'h00);
         check("array", ex(17'h1234a), rsp_rdata);
      end
   endtask
   task t_hv;
      for (i = 0; i < 4; i = i + 1) begin
         op(2'h2, 17'h1fffc | i[16:0], 8'h00); check("id", CODES[8*i +: 8], rsp_rdata);
      end
   endtask
   task t_prot;
      for (i = 0; i < 4; i = i + 1) begin
         op(2'h3, {i[1:0], 15'h0000}, 8'h00);
         check("prot", {7'h00, PROT[i]}, rsp_rdata);
         check("flag", {7'h00, PROT[i]}, {7'h00, rsp_protected});
      end
   endtask
   // Each write ends with a deselect, so the busy read also
   task t_erase;
      begin
         op(2'h1, 17'h18000, CMD_SEC); op(2'h0, 17'h1c123, 8'h00);
         check("busy", STAT, rsp_rdata);
         repeat (600) @(posedge clk_sys);
         op(2'h0, 17'h1c123, 8'h00); check("erased", ERASED, rsp_rdata);
         op(2'h0, 17'h17fff, 8'h00); check("kept", ex(17'h17fff), rsp_rdata);
         op(2'h1, 17'h08000, CMD_SEC); repeat (600) @(posedge clk_sys);
         op(2'h0, 17'h0a000, 8'h00); check("erased", ERASED, rsp_rdata);
         op(2'h0, 17'h1234a, 8'h00); check("kept", ex(17'h1234a), rsp_rdata);
         op(2'h1, 17'h00000, CMD_ALL); repeat (600) @(posedge clk_sys);
         op(2'h0, 17'h1234a, 8'h00); check("erased", ERASED, rsp_rdata);
      end
   endtask
   task report_and_stop;
      begin
         $display("checks %0d mismatches %0d", n_tests, bad_count);
         if (bad_count == 0 && n_tests > 0) $display("All tests passed");
         else $display("Some tests failed");
         $finish;
      end
   endtask
   initial begin
      rstn = 1'b0; req_valid = 1'b0; req_op = 2'h0; req_addr = 17'h00000; req_wdata = 8'h00;
      repeat (2) @(posedge clk_sys);
      rstn <= 1'b1;
      t_array; t_cmd; t_hv; t_prot; t_erase;
      report_and_stop;
   end
   // About 25 operations of 30 cycles plus three erase waits; ample margin
   initial begin
      #40000;
      bad_count = bad_count + 1;
      report_and_stop;
   end
endmodule // testbench
